// ===== src/sspi_pkg.sv
package sspi_pkg;

    // ----------------------------------------
    // control and status bit positions
    // ----------------------------------------
    localparam int CTRL_SELECT_IGNORE = 7;
    localparam int CTRL_ENABLE        = 6;
    localparam int CTRL_ROLE          = 4;
    localparam int CTRL_RATE_HI       = 1;
    localparam int CTRL_RATE_LO       = 0;
    localparam int STAT_DONE          = 7;
    localparam int STAT_COLLISION     = 6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ----------------------------------------
    // timing: 3 Mbps at 12 MHz is a divide by 4
    // ----------------------------------------
    localparam int SYS_CLK_HZ       = 50_000_000;
    localparam int REF_CLK_HZ       = 12_000_000;
    localparam int MAX_BIT_RATE_BPS = 3_000_000;
    localparam int FAST_DIV         = REF_CLK_HZ / MAX_BIT_RATE_BPS;
    localparam logic [7:0] HALF_DIV0 = 8'(FAST_DIV / 2);
    localparam logic [7:0] HALF_DIV1 = 8'h08;
    localparam logic [7:0] HALF_DIV2 = 8'h20;
    localparam logic [7:0] HALF_DIV3 = 8'h40;
    localparam logic [2:0] LAST_BIT  = 3'h7;

    // ----------------------------------------
    // master engine states
    // ----------------------------------------
    typedef enum logic [1:0] {
        M_IDLE = 2'b01,
        M_RUN  = 2'b10
    } master_state_t;

endpackage

// ===== src/sync_serial_port.sv
// Behaviour
// - serial rate reaches clock divided by four in both roles
// - full duplex: bits shift out and in together on the serial clock
// - mosi carries master to slave, miso slave to master; own line only
// - serial clock pin driven as master while transferring or with ignore 1, taken as input as slave
// - with enable at 0 the three serial pins act as plain port pins
// - enable resets to 0; while 0 the select input is ignored
// - master with select pin configured as output ignores select input
// - select-ignore at 1 disregards the select input
// - master with select low and ignore 0 becomes slave, sets done flag
// - slave is selected while its select input is low
// - single master: slave keeps ignore 0, master drives select from any pin
// - two devices idle as masters, ignore 0, select pin quasi-bidirectional
// - status holds readable done and collision flags
// - data write as enabled master starts the clock and shifting
// - after one byte the clock stops and the done flag sets
// - on conversion mosi and clock become inputs, miso output, role cleared
// - data write during transfer sets collision, byte dropped; write 1 clears
`timescale 1ns/10ps
`default_nettype none

module sync_serial_port (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       ctrl_we,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       status_we,
    input  wire logic [7:0] status_wdata,
    input  wire logic       data_we,
    input  wire logic [7:0] data_wdata,
    input  wire logic       select_port_is_output,
    output logic      [7:0] serial_control_reg,
    output logic      [7:0] serial_status_reg,
    output logic      [7:0] serial_data_reg,
    input  wire logic [2:0] gpio_out,
    input  wire logic [2:0] gpio_oe_n,
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe_n,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe_n,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe_n,
    input  wire logic       slave_select_pin
);

    // ----------------------------------------
    // control decode
    // ----------------------------------------
    logic       enable_bit;
    logic       role_bit;
    logic       ignore_bit;
    logic [1:0] rate_sel;
    logic       slave_role;
    logic       master_role;

    assign enable_bit  = serial_control_reg[sspi_pkg::CTRL_ENABLE];
    assign role_bit    = serial_control_reg[sspi_pkg::CTRL_ROLE];
    assign ignore_bit  = serial_control_reg[sspi_pkg::CTRL_SELECT_IGNORE];
    assign rate_sel    = serial_control_reg[sspi_pkg::CTRL_RATE_HI:sspi_pkg::CTRL_RATE_LO];
    assign slave_role  = enable_bit & ~role_bit;
    assign master_role = enable_bit & role_bit;

    function automatic logic [7:0] half_period(input logic [1:0] sel);
        case (sel)
            2'h0:    half_period = sspi_pkg::HALF_DIV0;
            2'h1:    half_period = sspi_pkg::HALF_DIV1;
            2'h2:    half_period = sspi_pkg::HALF_DIV2;
            default: half_period = sspi_pkg::HALF_DIV3;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] ss_sync;
    logic [1:0] miso_sync;
    logic       ss_low;
    logic       miso_s;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ss_sync   <= 2'h3;
            miso_sync <= 2'h0;
        end else begin
            ss_sync   <= {ss_sync[0], slave_select_pin};
            miso_sync <= {miso_sync[0], miso_i};
        end
    end

    assign ss_low = ~ss_sync[1];
    assign miso_s = miso_sync[1];

    // ----------------------------------------
    // select qualification
    // ----------------------------------------
    logic select_heeded;
    logic mode_change;
    logic slave_busy;

    assign select_heeded = enable_bit & ~ignore_bit & ~(role_bit & select_port_is_output);
    assign mode_change   = master_role & select_heeded & ss_low;
    assign slave_busy    = slave_role & select_heeded & ss_low;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            serial_control_reg <= sspi_pkg::CTRL_RESET;
        end else if (mode_change) begin
            serial_control_reg[sspi_pkg::CTRL_ROLE] <= 1'b0;
        end else if (ctrl_we) begin
            serial_control_reg <= ctrl_wdata;
        end
    end

    // ----------------------------------------
    // master engine
    // ----------------------------------------
    sspi_pkg::master_state_t state;
    logic [7:0] div_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic       sclk_q;
    logic       master_busy;
    logic       half_tick;
    logic       start;
    logic       collide;
    logic       master_done;

    assign master_busy = (state == sspi_pkg::M_RUN);
    assign half_tick   = master_busy & (div_cnt == 8'h01);
    assign collide     = data_we & (master_busy | slave_busy);
    assign start       = data_we & master_role & ~collide & ~mode_change;
    assign master_done = half_tick & sclk_q & (bit_cnt == sspi_pkg::LAST_BIT);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= sspi_pkg::M_IDLE;
        end else begin
            case (state)
                sspi_pkg::M_IDLE: begin
                    if (start) begin
                        state <= sspi_pkg::M_RUN;
                    end
                end
                sspi_pkg::M_RUN: begin
                    if (mode_change || master_done || !master_role) begin
                        state <= sspi_pkg::M_IDLE;
                    end
                end
                default: state <= sspi_pkg::M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            div_cnt  <= 8'h00;
            bit_cnt  <= 3'h0;
            sclk_q   <= 1'b0;
            tx_shift <= 8'h00;
            rx_shift <= 8'h00;
        end else if (start && !master_busy) begin
            div_cnt  <= half_period(rate_sel);
            bit_cnt  <= 3'h0;
            sclk_q   <= 1'b0;
            tx_shift <= data_wdata;
        end else if (half_tick) begin
            div_cnt <= half_period(rate_sel);
            sclk_q  <= ~sclk_q;
            if (!sclk_q) begin
                rx_shift <= {rx_shift[6:0], miso_s};
            end else if (bit_cnt != sspi_pkg::LAST_BIT) begin
                bit_cnt  <= bit_cnt + 3'h1;
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end else if (master_busy) begin
            div_cnt <= div_cnt - 8'h01;
        end else begin
            sclk_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // slave link domain
    // ----------------------------------------
    logic       link_clear;
    logic       link_role_clear;
    logic [2:0] link_cnt;
    logic [6:0] link_rx;
    logic [7:0] link_byte;
    logic       link_tgl;
    logic [7:0] tx_hold;

    assign link_role_clear = ~slave_role;
    assign link_clear      = link_role_clear | (slave_select_pin & ~ignore_bit);

    always_ff @(posedge serial_clock_pin_i or posedge link_clear) begin
        if (link_clear) begin
            link_cnt <= 3'h0;
            link_rx  <= 7'h00;
        end else begin
            link_cnt <= link_cnt + 3'h1;
            link_rx  <= {link_rx[5:0], mosi_i};
        end
    end

    always_ff @(posedge serial_clock_pin_i or posedge link_role_clear) begin
        if (link_role_clear) begin
            link_tgl  <= 1'b0;
            link_byte <= 8'h00;
        end else if (link_cnt == sspi_pkg::LAST_BIT && !link_clear) begin
            link_tgl  <= ~link_tgl;
            link_byte <= {link_rx, mosi_i};
        end
    end

    // ----------------------------------------
    // slave byte crossing
    // ----------------------------------------
    logic [2:0] tgl_sync;
    logic       slave_done;

    always_ff @(posedge clock) begin
        if (!rstn || !slave_role) begin
            tgl_sync <= 3'h0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], link_tgl};
        end
    end

    assign slave_done = tgl_sync[2] ^ tgl_sync[1];

    // ----------------------------------------
    // data and status registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_hold <= sspi_pkg::DATA_RESET;
        end else if (data_we && !collide) begin
            tx_hold <= data_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            serial_data_reg <= sspi_pkg::DATA_RESET;
        end else if (master_done) begin
            serial_data_reg <= rx_shift;
        end else if (slave_done) begin
            serial_data_reg <= link_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            serial_status_reg <= sspi_pkg::STAT_RESET;
        end else begin
            if (master_done || slave_done || mode_change) begin
                serial_status_reg[sspi_pkg::STAT_DONE] <= 1'b1;
            end else if (status_we && status_wdata[sspi_pkg::STAT_DONE]) begin
                serial_status_reg[sspi_pkg::STAT_DONE] <= 1'b0;
            end
            if (collide) begin
                serial_status_reg[sspi_pkg::STAT_COLLISION] <= 1'b1;
            end else if (status_we && status_wdata[sspi_pkg::STAT_COLLISION]) begin
                serial_status_reg[sspi_pkg::STAT_COLLISION] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    logic master_drive;
    logic miso_bit;

    assign master_drive = master_role & ~mode_change & (master_busy | ignore_bit);
    assign miso_bit     = tx_hold[3'h7 - link_cnt];

    always_comb begin
        if (!enable_bit) begin
            serial_clock_pin_o    = gpio_out[0];
            serial_clock_pin_oe_n = gpio_oe_n[0];
            mosi_o                = gpio_out[1];
            mosi_oe_n             = gpio_oe_n[1];
            miso_o                = gpio_out[2];
            miso_oe_n             = gpio_oe_n[2];
        end else begin
            serial_clock_pin_o    = sclk_q;
            serial_clock_pin_oe_n = ~master_drive;
            mosi_o                = tx_shift[7];
            mosi_oe_n             = ~master_drive;
            miso_o                = miso_bit;
            miso_oe_n             = ~(slave_role & (ignore_bit | ss_low));
        end
    end

endmodule

`default_nettype wire

// ===== dv/sspi_props.sv
`timescale 1ns/10ps
`default_nettype none

module sspi_props (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       ctrl_we,
    input wire logic       data_we,
    input wire logic [7:0] data_wdata,
    input wire logic       select_port_is_output,
    input wire logic [7:0] serial_control_reg,
    input wire logic [7:0] serial_status_reg,
    input wire logic       serial_clock_pin_oe_n,
    input wire logic       mosi_o,
    input wire logic       mosi_oe_n,
    input wire logic       miso_oe_n,
    input wire logic       slave_select_pin
);
    // ----------------------------------------
    // decoded control and status
    // ----------------------------------------
    wire logic en = serial_control_reg[6];
    wire logic ms = en && serial_control_reg[4] && !serial_control_reg[7];
    wire logic sl = en && !serial_control_reg[4];
    wire logic dn = serial_status_reg[7];
    wire logic b7 = data_wdata[7];
    wire logic go = data_we && ms && serial_clock_pin_oe_n && slave_select_pin;

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    a_reset_value: assert property ($rose(rstn) |-> serial_control_reg == 8'h04 && !dn)
        else $error("reset value wrong");
    a_slave_released: assert property (sl |-> serial_clock_pin_oe_n && mosi_oe_n)
        else $error("slave drives clock or mosi");
    a_unselected_idle: assert property (
        (sl && !serial_control_reg[7] && slave_select_pin) [*4] |-> miso_oe_n)
        else $error("unselected slave drives miso");
    a_start_shift: assert property (go |=> !serial_clock_pin_oe_n && mosi_o == $past(b7))
        else $error("transfer did not start");
    a_done_timing: assert property (
        go && serial_control_reg[1:0] == 2'h0 && !dn |-> ##32 !dn ##1 dn)
        else $error("done flag timing wrong");
    a_collision_set: assert property (
        data_we && ms && !serial_clock_pin_oe_n |=> serial_status_reg[6])
        else $error("collision flag not set");
    a_mode_change: assert property (
        ms && !select_port_is_output && !slave_select_pin && !ctrl_we |-> ##[1:4] (sl && dn))
        else $error("no mode change to slave");
    a_select_ignored: assert property (
        en && serial_control_reg[4] && (select_port_is_output || serial_control_reg[7]) && !ctrl_we
        |=> serial_control_reg[4])
        else $error("role lost while select ignored");
endmodule

bind sync_serial_port sspi_props i_props (
    .clock, .rstn, .ctrl_we, .data_we, .data_wdata, .select_port_is_output,
    .serial_control_reg, .serial_status_reg, .serial_clock_pin_oe_n,
    .mosi_o, .mosi_oe_n, .miso_oe_n, .slave_select_pin
);

`default_nettype wire

// ===== dv/far_peer.sv
`timescale 1ns/10ps
`default_nettype none

module far_peer (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       miso,
    input  wire logic [7:0] tx,
    output logic            sck_d,
    output logic            mosi_d,
    output logic            miso_d,
    output logic            ss_n,
    output logic      [7:0] rx
);
    logic [2:0] cnt;

    initial begin
        {sck_d, mosi_d, ss_n} = 3'h1;
        cnt = 3'h0;
        rx = 8'h00;
    end

    // ----------------------------------------
    // slave side, mode 0, msb first
    // ----------------------------------------
    always @(posedge sck) begin
        rx <= {rx[6:0], mosi};
        cnt <= cnt + 3'h1;
    end
    assign miso_d = tx[~cnt];

    // ----------------------------------------
    // master side, 160 ns serial clock
    // ----------------------------------------
    task automatic master_byte(input logic [7:0] v, output logic [7:0] g);
        ss_n = 1'b0;
        #167;
        for (int i = 7; i >= 0; i--) begin
            mosi_d = v[i];
            #80;
            sck_d = 1'b1;
            g[i] = miso;
            #80;
            sck_d = 1'b0;
        end
        #80;
        ss_n = 1'b1;
        mosi_d = ~mosi_d;
    endtask
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic       clock, rstn, ctrl_we, status_we, data_we, spo, ss_tb, ssel;
    logic       sck, sck_o, sck_oe_n, mosi, mosi_o, mosi_oe_n, miso, miso_o, miso_oe_n;
    logic       p_sck, p_mosi, p_miso, p_ss_n;
    logic [7:0] ctrl_wdata, status_wdata, data_wdata, ctl, st, dat, p_tx, p_rx, seed, b, got;
    logic [2:0] gpio_out, gpio_oe_n;
    int         n_mismatch, num_checks, cyc, n;

    assign sck  = !sck_oe_n ? sck_o : p_sck;
    assign mosi = !mosi_oe_n ? mosi_o : p_mosi;
    assign miso = !miso_oe_n ? miso_o : p_miso;
    assign ssel = p_ss_n & ss_tb;

    sync_serial_port i_dut (
        .clock, .rstn, .ctrl_we, .ctrl_wdata, .status_we, .status_wdata,
        .data_we, .data_wdata, .select_port_is_output(spo),
        .serial_control_reg(ctl), .serial_status_reg(st), .serial_data_reg(dat),
        .gpio_out, .gpio_oe_n, .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_n(sck_oe_n), .mosi_i(mosi), .mosi_o, .mosi_oe_n,
        .miso_i(miso), .miso_o, .miso_oe_n, .slave_select_pin(ssel)
    );

    far_peer i_peer (
        .sck, .mosi, .miso, .tx(p_tx), .sck_d(p_sck), .mosi_d(p_mosi),
        .miso_d(p_miso), .ss_n(p_ss_n), .rx(p_rx)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [15:0] exp_cyc(input logic [1:0] r);
        logic [7:0] h;
        h = r[1] ? (r[0] ? sspi_pkg::HALF_DIV3 : sspi_pkg::HALF_DIV2)
                 : (r[0] ? sspi_pkg::HALF_DIV1 : sspi_pkg::HALF_DIV0);
        return {8'h0, h} * 16'h10 + 16'h1;
    endfunction

    task automatic tick();
        @(posedge clock);
        #2;
    endtask

    task automatic wr(input logic [2:0] k, input logic [7:0] v);
        {data_we, status_we, ctrl_we} = k;
        {ctrl_wdata, status_wdata, data_wdata} = {3{v}};
        tick();
        {data_we, status_we, ctrl_we} = 3'h0;
        tick();
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {ctrl_we, status_we, data_we, spo, rstn} = 5'h0;
        ss_tb = 1'b1;
        {gpio_oe_n, gpio_out} = 6'h38;
        {ctrl_wdata, status_wdata, data_wdata, p_tx} = 32'h0;
        seed = 8'h26;
        repeat (5) tick();
        rstn = 1'b1;
        chk("control", 8'h04, ctl);
        chk("status", 8'h00, st);
        repeat (4) begin
            seed = lfsr(seed);
            {gpio_oe_n, gpio_out} = seed[5:0];
            tick();
            chk("pins", {2'h0, seed[5:0]}, {2'h0, miso_oe_n, mosi_oe_n, sck_oe_n, miso_o, mosi_o, sck_o});
        end
        for (int r = 0; r < 4; r++) begin
            wr(3'h1, {6'h14, r[1:0]});
            seed = lfsr(seed);
            b = seed;
            seed = lfsr(seed);
            p_tx = seed;
            i_peer.cnt = 3'h0;
            wr(3'h4, b);
            wr(3'h4, ~b);
            n = 4;
            while (st[7] !== 1'b1 && n < 1100) begin
                tick();
                n++;
            end
            num_checks++;
            if (n[15:0] !== exp_cyc(r[1:0])) begin
                n_mismatch++;
                $display("mismatch cycles expected %0d seen %0d", exp_cyc(r[1:0]), n);
            end
            chk("status", 8'hC0, st);
            chk("rx", p_tx, dat);
            chk("peer rx", b, p_rx);
            wr(3'h2, 8'hC0);
            chk("cleared", 8'h00, st);
        end
        for (int k = 0; k < 3; k++) begin
            spo = (k == 1);
            wr(3'h1, (k == 0) ? 8'h10 : (k == 1) ? 8'h50 : 8'hD0);
            ss_tb = 1'b0;
            repeat (6) tick();
            chk("role", 8'h10, ctl & 8'h10);
            chk("status", 8'h00, st);
            ss_tb = 1'b1;
            repeat (3) tick();
        end
        spo = 1'b0;
        wr(3'h1, 8'h50);
        ss_tb = 1'b0;
        repeat (6) tick();
        chk("mode change", 8'h40, ctl);
        chk("status", 8'h80, st);
        wr(3'h4, 8'h3C);
        chk("slave collision", 8'hC0, st);
        ss_tb = 1'b1;
        wr(3'h2, 8'hC0);
        repeat (3) begin
            seed = lfsr(seed);
            b = seed;
            seed = lfsr(seed);
            wr(3'h4, b);
            i_peer.cnt = 3'h0;
            i_peer.master_byte(seed, got);
            repeat (8) tick();
            chk("slave rx", seed, dat);
            chk("slave tx", b, got);
            chk("status", 8'h80, st);
            wr(3'h2, 8'hC0);
        end
        close_out();
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
endmodule

`default_nettype wire
